//--- flash_led_cfg_pkg.sv
// Package: register map, field layout, reset values and timing for the LED config bank
package flash_led_cfg_pkg;

  // Register offsets
  localparam logic [7:0] OFS_LOW_SUPPLY   = 8'h04;
  localparam logic [7:0] OFS_INDICATOR    = 8'h05;
  localparam logic [7:0] OFS_FIRST_FLASH  = 8'h06;
  localparam logic [7:0] OFS_SECOND_FLASH = 8'h07;
  localparam logic [7:0] OFS_FIRST_MASK   = 8'h08;
  localparam logic [7:0] OFS_SECOND_MASK  = 8'h09;
  localparam logic [7:0] OFS_APPLIED      = 8'h0a;
  localparam logic [7:0] OFS_LOWEST       = 8'h0b;

  // Reset values
  localparam logic [7:0] RST_LOW_SUPPLY   = 8'hf4;  // threshold 111, shutdown 1, limit 0100
  localparam logic [7:0] RST_INDICATOR    = 8'h14;  // thermal 0, ramp 001, pass 01, duty 00
  localparam logic [7:0] RST_LEVEL        = 8'h33;
  localparam logic [7:0] RST_REPORT       = 8'h00;

  // Field codes
  localparam logic [2:0] THRESH_OFF       = 3'h7;
  localparam logic [3:0] LIMIT_OFF        = 4'hc;
  localparam logic [3:0] LIMIT_KNEE       = 4'h8;
  localparam logic [1:0] MODE_STANDBY     = 2'h0;
  localparam logic [1:0] MODE_INDICATOR   = 2'h1;
  localparam logic [1:0] MODE_ASSIST      = 2'h2;
  localparam logic [1:0] MODE_FLASH       = 2'h3;

  // Analog scales (millivolt / milliamp / degrees C)
  localparam int THRESH_BASE_MV   = 3000;
  localparam int THRESH_STEP_MV   = 100;
  localparam int LIMIT_BASE_MA    = 1660;
  localparam int LIMIT_STEP1_MA   = 330;
  localparam int LIMIT_KNEE_MA    = 4300;
  localparam int LIMIT_STEP2_MA   = 400;
  localparam int PASS_BASE_MV     = 300;
  localparam int PASS_STEP_MV     = 150;
  localparam int HOT_REDUCE_C     = 130;
  localparam int HOT_SHUTDOWN_C   = 150;

  // Timing
  localparam int CLK_MHZ          = 250;
  localparam int RAMP_MAX_US      = 8;
  localparam int CYCLES_PER_US    = CLK_MHZ;
  localparam int PWM_FREQ_HZ      = 31500;
  localparam int PWM_SLOT_CYCLES  = (CLK_MHZ * 1000000) / (PWM_FREQ_HZ * 16);
  localparam int DUTY_BASE        = 2;

  // Register write request
  typedef struct packed {
    logic       write;
    logic [7:0] addr;
    logic [7:0] data;
  } reg_req_s;

  // Environment measurements from the analog side
  typedef struct packed {
    logic [12:0] supplyMv;
    logic [7:0]  junctionC;
  } sense_s;

  // Per-LED current drive
  typedef struct packed {
    logic [7:0] first;
    logic [7:0] second;
  } drive_s;

  typedef enum logic [1:0] {
    RAMP_IDLE = 2'b00,
    RAMP_UP   = 2'b01,
    RAMP_HOLD = 2'b11,
    RAMP_OFF  = 2'b10
  } ramp_e;

  // Low-supply threshold in millivolts
  function automatic logic [12:0] threshMv(input logic [2:0] code);
    threshMv = 13'(THRESH_BASE_MV + THRESH_STEP_MV * int'(code));
  endfunction : threshMv

  // Ramp step hold in cycles: 8us at 000 down to 1us at 111
  function automatic logic [11:0] stepCycles(input logic [2:0] code);
    stepCycles = 12'((RAMP_MAX_US - int'(code)) * CYCLES_PER_US);
  endfunction : stepCycles

endpackage : flash_led_cfg_pkg

//--- flash_led_config_regs.sv
// Configuration and status register bank with flash current control
module flash_led_config_regs
  import flash_led_cfg_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire reg_req_s    regReq,       // Write strobe, address, data
  output logic      [7:0]  regRdata,     // Read data for regReq.addr
  input  wire logic [1:0]  operatingMode, // Mode field from mode register
  input  wire logic        flashTrigger, // Level: flash pulse active
  input  wire logic        transmitIn,   // Transmit mask input
  input  wire sense_s      sense,        // Supply and temperature
  input  wire logic [12:0] inputCurrentMa, // Measured input current
  input  wire logic [9:0]  headroomMv,   // Output minus input voltage
  output drive_s           ledDrive,     // Per-LED current codes
  output logic             inputLimitHit, // Input current over limit
  output logic             passMode,     // Headroom under pass threshold
  output logic             indicatorPwm, // Indicator PWM waveform
  output logic             hotShutdown   // Thermal shutdown asserted
);

  logic [7:0] lowSupplyReg;   // Threshold, shutdown, input limit
  logic [7:0] indicatorReg;   // Thermal, ramp, pass, duty
  drive_s     flashLevel;     // Flash level codes
  drive_s     maskedLevel;    // Transmit-masked level codes
  logic [7:0] appliedLevel;   // Reported applied level
  logic [7:0] lowestLevel;    // Reported lowest reduced level
  ramp_e      rampState;      // Ramp state
  logic [7:0] rampLevel;      // Ramp multiplier out of 255
  logic [11:0] stepCount;     // Step hold counter
  logic       reduced;        // Reduction happened this flash
  logic [8:0] pwmDiv;         // PWM slot divider, slot is 496 cycles
  logic [3:0] pwmSlot;        // PWM slot within period

  logic        supplyLow;
  logic        hotReduce;
  logic [7:0]  firstTarget;
  logic [7:0]  secondTarget;
  logic [12:0] limitMa;
  logic        inFlash;

  // Field views
  wire logic [2:0] lowSupplyThreshold  = lowSupplyReg[7:5];
  wire logic       lowSupplyShutdown   = lowSupplyReg[4];
  wire logic [3:0] inputCurrentLimit   = lowSupplyReg[3:0];
  wire logic       adaptiveThermal     = indicatorReg[7];
  wire logic [2:0] rampStepTime        = indicatorReg[6:4];
  wire logic [1:0] passModeThreshold   = indicatorReg[3:2];
  wire logic [1:0] indicatorDuty       = indicatorReg[1:0];

  // Flash mode decode
  assign inFlash = (operatingMode == MODE_FLASH) && flashTrigger;

  // Supply comparison against programmed threshold
  always_comb
  begin
    supplyLow = (lowSupplyThreshold != THRESH_OFF) &&
                (sense.supplyMv < threshMv(lowSupplyThreshold));
  end

  // Input current limit decode
  always_comb
  begin
    if (inputCurrentLimit <= LIMIT_KNEE)
      limitMa = 13'(LIMIT_BASE_MA + LIMIT_STEP1_MA * int'(inputCurrentLimit));
    else
      limitMa = 13'(LIMIT_KNEE_MA + LIMIT_STEP2_MA * (int'(inputCurrentLimit) - 8));
    inputLimitHit = (inputCurrentLimit < LIMIT_OFF) &&
                    (inputCurrentMa > limitMa);
  end

  // Pass mode threshold compare
  always_comb
  begin
    passMode = int'(headroomMv) <
               (PASS_BASE_MV + PASS_STEP_MV * int'(passModeThreshold));
  end

  // Thermal handling
  always_comb
  begin
    hotReduce   = adaptiveThermal && (int'(sense.junctionC) > HOT_REDUCE_C);
    hotShutdown = !adaptiveThermal && (int'(sense.junctionC) > HOT_SHUTDOWN_C);
  end

  // Target level choice: masked under transmit, thermal or low start
  always_comb
  begin
    if (transmitIn || hotReduce || (rampState == RAMP_HOLD))
    begin
      firstTarget  = maskedLevel.first;
      secondTarget = maskedLevel.second;
    end
    else
    begin
      firstTarget  = flashLevel.first;
      secondTarget = flashLevel.second;
    end
  end

  // Host writes; report registers are not writable
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      lowSupplyReg <= RST_LOW_SUPPLY;
      indicatorReg <= RST_INDICATOR;
      flashLevel   <= '{RST_LEVEL, RST_LEVEL};
      maskedLevel  <= '{RST_LEVEL, RST_LEVEL};
    end
    else if (regReq.write)
    begin
      unique case (regReq.addr)
        OFS_LOW_SUPPLY:   lowSupplyReg       <= regReq.data;
        OFS_INDICATOR:    indicatorReg       <= regReq.data;
        OFS_FIRST_FLASH:  flashLevel.first   <= regReq.data;
        OFS_SECOND_FLASH: flashLevel.second  <= regReq.data;
        OFS_FIRST_MASK:   maskedLevel.first  <= regReq.data;
        OFS_SECOND_MASK:  maskedLevel.second <= regReq.data;
        default:          ; // Reports and unmapped ignored
      endcase
    end
  end

  // Read mux
  always_comb
  begin
    unique case (regReq.addr)
      OFS_LOW_SUPPLY:   regRdata = lowSupplyReg;
      OFS_INDICATOR:    regRdata = indicatorReg;
      OFS_FIRST_FLASH:  regRdata = flashLevel.first;
      OFS_SECOND_FLASH: regRdata = flashLevel.second;
      OFS_FIRST_MASK:   regRdata = maskedLevel.first;
      OFS_SECOND_MASK:  regRdata = maskedLevel.second;
      OFS_APPLIED:      regRdata = appliedLevel;
      OFS_LOWEST:       regRdata = lowestLevel;
      default:          regRdata = 8'h00;
    endcase
  end

  // Ramp state machine with step timing and low-supply handling
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      rampState <= RAMP_IDLE;
      rampLevel <= 8'h00;
      stepCount <= 12'h000;
    end
    else if (!inFlash || hotShutdown)
    begin
      rampState <= RAMP_IDLE;
      rampLevel <= 8'h00;
      stepCount <= 12'h000;
    end
    else
    begin
      unique case (rampState)
        RAMP_IDLE:
        begin
          stepCount <= stepCycles(rampStepTime);
          if (supplyLow && lowSupplyShutdown)
            rampState <= RAMP_OFF;   // Stay disabled
          else if (supplyLow)
            rampState <= RAMP_HOLD;  // Go to masked level
          else
            rampState <= RAMP_UP;
        end
        RAMP_UP:
        begin
          if (supplyLow)
            stepCount <= stepCount; // Ramping halted
          else if (stepCount != 12'h000)
            stepCount <= stepCount - 12'h001; // Hold each step
          else if (rampLevel != 8'hff)
          begin
            rampLevel <= rampLevel + 8'h01;
            stepCount <= stepCycles(rampStepTime);
          end
        end
        RAMP_HOLD:
        begin
          rampLevel <= 8'hff;
        end
        RAMP_OFF:
        begin
          rampLevel <= 8'h00;
        end
      endcase
    end
  end

  // Output current: ramp fraction of target, then reduction in flash
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      ledDrive     <= '{8'h00, 8'h00};
      appliedLevel <= RST_REPORT;
      lowestLevel  <= RST_REPORT;
      reduced      <= 1'b0;
    end
    else if (!inFlash || hotShutdown)
    begin
      ledDrive <= '{8'h00, 8'h00};
      reduced  <= 1'b0;
    end
    else if (supplyLow && (rampState == RAMP_UP) && (rampLevel == 8'hff))
    begin
      // Step current down until supply recovers
      ledDrive.first  <= (ledDrive.first  != 8'h00) ? ledDrive.first  - 8'h01 : 8'h00;
      ledDrive.second <= (ledDrive.second != 8'h00) ? ledDrive.second - 8'h01 : 8'h00;
      if (!reduced || (ledDrive.first < lowestLevel))
        lowestLevel <= ledDrive.first;
      reduced      <= 1'b1;
      appliedLevel <= ledDrive.first;
    end
    else if (!reduced || !supplyLow)
    begin
      ledDrive.first  <= 8'((16'(firstTarget)  * 16'(rampLevel)) / 16'd255);
      ledDrive.second <= 8'((16'(secondTarget) * 16'(rampLevel)) / 16'd255);
      appliedLevel    <= ledDrive.first;
    end
  end

  // Indicator PWM: 16 slots per 31.5kHz period
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      pwmDiv       <= 9'h000;
      pwmSlot      <= 4'h0;
      indicatorPwm <= 1'b0;
    end
    else
    begin
      // Slot length exceeds 8 bits, so the divider is 9 bits wide
      if (pwmDiv == 9'(PWM_SLOT_CYCLES - 1))
      begin
        pwmDiv  <= 9'h000;
        pwmSlot <= pwmSlot + 4'h1;
      end
      else
        pwmDiv <= pwmDiv + 9'h001;
      indicatorPwm <= (operatingMode == MODE_INDICATOR) &&
                      (int'(pwmSlot) < DUTY_BASE + int'(indicatorDuty));
    end
  end

endmodule : flash_led_config_regs

//--- cfg_host_model.sv
// Host model: register writes and reads on the bank's bus
module cfg_host_model
  import flash_led_cfg_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic [7:0] regRdata,
  output reg_req_s        regReq
);
  timeunit 1ns;
  timeprecision 1ps;
  initial regReq = '0;
  // Strobe held over one rising edge, then dropped
  task automatic write(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    regReq = '{write: 1'b1, addr: a, data: d};
    @(negedge sys_clk);
    regReq.write = 1'b0;
    regReq.data = ~d;  // Stale data not left on the bus
  endtask : write
  // Address set, data taken at the next rising edge
  task automatic read(input logic [7:0] a, output logic [7:0] d);
    @(negedge sys_clk);
    regReq.addr = a;
    @(posedge sys_clk);
    d = regRdata;
  endtask : read
endmodule : cfg_host_model

//--- flash_led_config_regs_monitor.sv
// Checker: port-level assertions for the LED configuration bank
module flash_led_config_regs_monitor
  import flash_led_cfg_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire reg_req_s    regReq,
  input wire logic [7:0]  regRdata,
  input wire logic [1:0]  operatingMode,
  input wire logic        flashTrigger,
  input wire sense_s      sense,
  input wire logic [12:0] inputCurrentMa,
  input wire logic [9:0]  headroomMv,
  input wire drive_s      ledDrive,
  input wire logic        inputLimitHit,
  input wire logic        passMode,
  input wire logic        indicatorPwm,
  input wire logic        hotShutdown
);
  logic [3:0] limitCode;  // Shadow input limit field
  logic       thermalOn;  // Shadow adaptive thermal bit
  logic [1:0] passCode;   // Shadow pass threshold field
  int         limitMa;    // Decoded limit
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // Track field writes
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      limitCode <= RST_LOW_SUPPLY[3:0];
      {thermalOn, passCode} <= {RST_INDICATOR[7], RST_INDICATOR[3:2]};
    end
    else if (regReq.write && regReq.addr == OFS_LOW_SUPPLY)
      limitCode <= regReq.data[3:0];
    else if (regReq.write && regReq.addr == OFS_INDICATOR)
      {thermalOn, passCode} <= {regReq.data[7], regReq.data[3:2]};
  end
  // Limit decode, two slopes
  always_comb
    limitMa = (limitCode <= LIMIT_KNEE) ? LIMIT_BASE_MA + LIMIT_STEP1_MA * int'(limitCode)
            : LIMIT_KNEE_MA + LIMIT_STEP2_MA * (int'(limitCode) - 8);
  unmapped_zero_a: assert property ((regReq.addr < 8'h04 || regReq.addr > 8'h0b) |-> regRdata == 8'h00) else $error("unmapped read not zero");
  write_back_a: assert property ((regReq.write && regReq.addr inside {[8'h04:8'h09]}) ##1 $stable(regReq.addr) |-> regRdata == $past(regReq.data)) else $error("written value not read back");
  limit_hit_a: assert property (limitCode < LIMIT_OFF |-> inputLimitHit == (int'(inputCurrentMa) > limitMa)) else $error("input limit compare wrong");
  limit_off_a: assert property (limitCode >= LIMIT_OFF |-> !inputLimitHit) else $error("limit not disabled");
  pass_level_a: assert property (passMode == (int'(headroomMv) < PASS_BASE_MV + PASS_STEP_MV * int'(passCode))) else $error("pass threshold wrong");
  hot_off_a: assert property (!thermalOn && sense.junctionC > 8'd150 |-> hotShutdown) else $error("no thermal shutdown");
  hot_adapt_a: assert property (thermalOn || sense.junctionC <= 8'd150 |-> !hotShutdown) else $error("spurious shutdown");
  trig_drop_a: assert property ($fell(flashTrigger) |-> ##[1:2] ledDrive == '0) else $error("drive not cleared");
  pwm_quiet_a: assert property ((operatingMode != MODE_INDICATOR) [*2] |-> !indicatorPwm) else $error("pwm outside indicator");
  cover property (ledDrive != '0);
  cover property (inputLimitHit);
  cover property ($rose(indicatorPwm));
endmodule : flash_led_config_regs_monitor
bind flash_led_config_regs flash_led_config_regs_monitor flash_led_config_regs_monitor_i (.*);

//--- test_flash_led_config_regs.sv
// Testbench: register, comparator, PWM and flash scenarios
module test_flash_led_config_regs
  import flash_led_cfg_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0, rst = 1'b1, flashTrigger = 1'b0, transmitIn = 1'b0;
  logic [1:0] operatingMode = MODE_STANDBY;
  logic [12:0] inputCurrentMa = '0;
  logic [9:0] headroomMv = 10'h3ff;
  sense_s sense = '{supplyMv: 13'd3600, junctionC: 8'd25};
  reg_req_s regReq;
  logic [7:0] regRdata, rv;
  drive_s ledDrive;
  logic inputLimitHit, passMode, indicatorPwm, hotShutdown;
  int bad_count = 0, check_count = 0, lim, n;
  flash_led_config_regs flash_led_config_regs_i (.*);
  cfg_host_model cfg_host_model_i (.sys_clk(sys_clk), .regRdata(regRdata), .regReq(regReq));
  initial forever #2 sys_clk = ~sys_clk;
  task automatic end_sim();
    $display("checks=%0d mismatches=%0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    cfg_host_model_i.read(a, rv);
    chk(16'(rv), 16'(e));
  endtask : rd
  // Cycles until pwm reaches a level, bounded
  task automatic pwm_wait(input logic lvl, output int cnt);
    cnt = 0;
    while (indicatorPwm !== lvl)
    begin
      @(negedge sys_clk);
      cnt++;
      if (cnt > 20000)
      begin
        bad_count++;
        end_sim();
      end
    end
  endtask : pwm_wait
  initial
  begin
    repeat (16) @(posedge sys_clk);
    @(negedge sys_clk) rst = 1'b0;
    foreach (RST_LEVEL[i]) rd(8'h04 + 8'(7 - i), {8'h00, 8'h00, {4{RST_LEVEL}}, RST_INDICATOR, RST_LOW_SUPPLY}[8*(7-i)+:8]);
    rd(8'h0c, 8'h00);
    $display("reset values done");
    for (int a = 4; a < 12; a++) cfg_host_model_i.write(8'(a), 8'ha0 + 8'(a));
    for (int a = 4; a < 12; a++) rd(8'(a), (a < 10) ? 8'ha0 + 8'(a) : 8'h00);
    $display("write and read back done");
    for (int c = 0; c < 13; c++)
    begin
      cfg_host_model_i.write(OFS_LOW_SUPPLY, {4'hf, 4'(c)});
      lim = (c <= 8) ? 1660 + 330 * c : 4300 + 400 * (c - 8);
      inputCurrentMa = (c == 12) ? 13'h1fff : 13'(lim);
      @(negedge sys_clk) chk(16'(inputLimitHit), 16'h0);
      inputCurrentMa = 13'(lim + 1);
      @(negedge sys_clk) chk(16'(inputLimitHit), (c == 12) ? 16'h0 : 16'h1);
    end
    $display("input limit done");
    for (int c = 0; c < 4; c++)
    begin
      cfg_host_model_i.write(OFS_INDICATOR, {4'h7, 2'(c), 2'h0});
      headroomMv = 10'(299 + 150 * c);
      @(negedge sys_clk) chk(16'(passMode), 16'h1);
      headroomMv = 10'(300 + 150 * c);
      @(negedge sys_clk) chk(16'(passMode), 16'h0);
    end
    sense.junctionC = 8'd151;
    @(negedge sys_clk) chk(16'(hotShutdown), 16'h1);
    cfg_host_model_i.write(OFS_INDICATOR, 8'hf4);
    @(negedge sys_clk) chk(16'(hotShutdown), 16'h0);
    sense.junctionC = 8'd25;
    $display("pass and thermal done");
    for (int d = 0; d < 4; d++)
    begin
      cfg_host_model_i.write(OFS_INDICATOR, {6'h1d, 2'(d)});
      operatingMode = MODE_INDICATOR;
      pwm_wait(1'b1, n);
      pwm_wait(1'b0, n);
      pwm_wait(1'b1, n);
      pwm_wait(1'b0, n);
      chk(16'(n), 16'((2 + d) * PWM_SLOT_CYCLES));
      operatingMode = MODE_STANDBY;
    end
    $display("indicator pwm done");
    cfg_host_model_i.write(OFS_FIRST_MASK, 8'h5a);
    cfg_host_model_i.write(OFS_SECOND_MASK, 8'ha5);
    cfg_host_model_i.write(OFS_LOW_SUPPLY, 8'h24);
    sense.supplyMv = 13'd3050;
    transmitIn = 1'b1;
    operatingMode = MODE_FLASH;
    flashTrigger = 1'b1;
    for (n = 0; n < 30 && ledDrive !== 16'h5aa5; n++) @(negedge sys_clk);
    chk(ledDrive, 16'h5aa5);
    rd(OFS_APPLIED, 8'h5a);
    @(negedge sys_clk) flashTrigger = 1'b0;
    cfg_host_model_i.write(OFS_LOW_SUPPLY, 8'h34);
    chk(ledDrive, 16'h0000);
    flashTrigger = 1'b1;
    repeat (30) @(negedge sys_clk);
    chk(ledDrive, 16'h0000);
    flashTrigger = 1'b0;
    $display("flash low supply done");
    end_sim();
  end
endmodule : test_flash_led_config_regs
